/* File: pkg/tsp_consts.vh */
// Constants for the test script processor core: register map, opcodes, fields, reset values.
// Assumes inclusion by its bare name from design files.
`ifndef TSP_CONSTS_VH
`define TSP_CONSTS_VH
// ========================================
// Register byte offsets on the APB.
`define OFS_CMD 12'h000
`define OFS_ACC 12'h004
`define OFS_FLAGS 12'h008
`define OFS_PC 12'h00C
`define OFS_ROLE 12'h010
`define OFS_PID 12'h014
`define OFS_SP 12'h018
`define OFS_GREG 12'h020
// ========================================
// Command word layout: opcode [23:20], selector [19:16], operand [15:0].
`define OP_HI 23
`define OP_LO 20
`define SEL_HI 19
`define SEL_LO 16
`define IMM_HI 15
`define IMM_LO 0
// ========================================
// Opcodes.
`define OPC_NOP 4'h0
`define OPC_ADD_REG_TO_ACC 4'h1
`define OPC_ADD_IMM_TO_ACC 4'h2
`define OPC_AND_IMM_WITH_ACC 4'h3
`define OPC_CALL 4'h4
`define OPC_FCLR 4'h5
`define OPC_ROLE 4'h6
`define OPC_COMPARE_ACC_REG 4'h7
`define OPC_COMPARE_ACC_IMM 4'h8
`define OPC_PID0 4'h9
`define OPC_PID1 4'hA
`define OPC_PID2 4'hB
`define OPC_PFLIP 4'hC
`define OPC_RET 4'hD
`define OPC_FSET 4'hE
// ========================================
// Flag bit positions.
`define FLG_BELOW 0
`define FLG_EQUAL 1
`define FLG_ABOVE 2
`define FLG_STKERR 3
// ========================================
// Roles and packet identifier codes.
`define ROLE_DETACHED 2'h0
`define ROLE_HOST 2'h1
`define ROLE_DEVICE 2'h2
`define ROLE_PERIPH 2'h3
`define PID_DATA0 2'h0
`define PID_DATA1 2'h1
`define PID_DATA2 2'h2
`define RST_WORD16 16'h0000
`define RST_FLAGS 8'h00
`endif

/* File: hw/return_stack.v */
// Hardware return stack for the test script processor.
// Assumes one push or pop per cycle from the core on the same clock.
`timescale 1ns/1ps
module return_stack #(
   parameter DEPTH = 8,
   parameter AW = 3,
   parameter W = 16
)(
   input wire pclk,
   input wire presetn,
   input wire push,
   input wire pop,
   input wire [W-1:0] din,
   output wire [W-1:0] dout,
   output wire [AW:0] level,
   output wire full,
   output wire empty
);
   localparam integer DEPTH_I = DEPTH;
   localparam [AW:0] FULL_LVL = DEPTH_I[AW:0];
   localparam [AW:0] ONE_LVL = {{AW{1'b0}}, 1'b1};
   reg [W-1:0] mem_r [0:DEPTH-1];
   reg [AW:0] sp_r;
   wire [AW:0] top_idx = sp_r - ONE_LVL;
   integer i;
   assign level = sp_r;
   assign full = (sp_r == FULL_LVL);
   assign empty = (sp_r == {(AW+1){1'b0}});
   assign dout = empty ? {W{1'b0}} : mem_r[top_idx[AW-1:0]];
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sp_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem_r[i] <= {W{1'b0}};
      end
      else if (push && !full)
      begin
         mem_r[sp_r[AW-1:0]] <= din;
         sp_r <= sp_r + ONE_LVL;
      end
      else if (pop && !empty)
         sp_r <= top_idx;
   end
endmodule // return_stack

/* File: hw/test_script_processor_core.v */
// Execution core of the scripted test processor, with an APB slave for commands and state.
// Assumes an APB master on pclk; a write to the command register executes one command.
//
// Notes on behaviour
// - add_reg_to_acc adds the selected general register into the accumulator.
// - add_imm_to_acc adds a 16-bit immediate into the accumulator.
// - and_imm_with_acc ANDs the accumulator with a 16-bit immediate.
// - Call pushes the program counter on the return stack, then jumps to target.
// - flag_clear_cmd clears only the selected flag to 0.
// - role_select_cmd picks a role; any role but detached enables the engine.
// - Pull-downs: both lines for host, one for peripheral, none otherwise.
// - compare_acc_reg updates flags; below_flag set when accumulator is smaller.
// - compare_acc_imm updates flags; below_flag set when accumulator is smaller.
// - grp1_next_pid_zero makes the next group 1 packet DATA0.
// - grp1_next_pid_one makes the next group 1 packet DATA1.
// - grp1_next_pid_two makes the next group 1 packet DATA2.
// - grp1_pid_flip swaps the next group 1 packet between DATA0 and DATA1.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "tsp_consts.vh"
module test_script_processor_core #(
   parameter NREG = 16,
   parameter STACK_DEPTH = 8,
   parameter STACK_AW = 3
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg serial_iface_engine_en,
   output reg pulldown_dp,
   output reg pulldown_dm,
   output reg [1:0] grp1_next_pid,
   output reg [1:0] role
);
   // ========================================
   // Architectural state.
   reg [15:0] acc_r;
   reg [15:0] pc_r;
   reg [7:0] flags_r;
   reg [15:0] greg_r [0:NREG-1];
   reg [15:0] acc_nxt;
   reg [15:0] pc_nxt;
   reg [7:0] flags_nxt;
   reg push;
   reg pop;
   reg [1:0] role_nxt;
   reg [1:0] pid_nxt;
   reg [31:0] rdata_nxt;
   reg rd_err;
   wire [15:0] stk_top;
   wire [STACK_AW:0] stk_level;
   wire stk_full;
   wire stk_empty;
   integer i;

   // ========================================
   // General register window as a byte range on the bus.
   localparam integer GREG_END_I = `OFS_GREG + NREG * 4;
   localparam [11:0] GREG_END = GREG_END_I[11:0];

   // ========================================
   // Bus phases. Decoding happens in the setup cycle so that read data and the error
   // answer stand in the access cycle. State changes only at the edge that completes
   // the transfer, when psel, penable and pready are all high.
   wire setup = psel && !penable;
   wire wr_setup = setup && pwrite;
   wire rd_setup = setup && !pwrite;
   wire done = psel && penable && pready;
   wire wr_done = done && pwrite;
   wire cmd_hit = (paddr == `OFS_CMD);
   wire cmd_wr = wr_done && cmd_hit;
   wire [3:0] opc = pwdata[`OP_HI:`OP_LO];
   wire [3:0] sel = pwdata[`SEL_HI:`SEL_LO];
   wire [15:0] imm = pwdata[`IMM_HI:`IMM_LO];
   wire [11:0] greg_off = paddr - `OFS_GREG;
   wire greg_hit = (paddr >= `OFS_GREG) && (paddr < GREG_END) && (paddr[1:0] == 2'b00);
   wire [3:0] greg_idx = greg_off[5:2];
   wire [15:0] sel_reg = greg_r[sel];

   // ========================================
   // Compare of accumulator against an operand, returning flags.
   function [7:0] cmp_flags;
      input [7:0] old;
      input [15:0] a;
      input [15:0] b;
      reg [7:0] f;
      begin
         f = old;
         f[`FLG_BELOW] = (a < b);
         f[`FLG_EQUAL] = (a == b);
         f[`FLG_ABOVE] = (a > b);
         cmp_flags = f;
      end
   endfunction

   // ========================================
   // Role decode: engine enable and line pull-downs for each role.
   function engine_for;
      input [1:0] r;
      begin
         engine_for = (r != `ROLE_DETACHED);
      end
   endfunction

   function pull_dp_for;
      input [1:0] r;
      begin
         pull_dp_for = (r == `ROLE_HOST);
      end
   endfunction

   function pull_dm_for;
      input [1:0] r;
      begin
         pull_dm_for = (r == `ROLE_HOST) || (r == `ROLE_PERIPH);
      end
   endfunction

   // ========================================
   // Packet identifier flip; DATA2 falls back to DATA0.
   function [1:0] pid_flip;
      input [1:0] p;
      begin
         pid_flip = (p == `PID_DATA0) ? `PID_DATA1 : `PID_DATA0;
      end
   endfunction

   return_stack #(
      .DEPTH(STACK_DEPTH),
      .AW(STACK_AW),
      .W(16)
   ) u_stack (
      .pclk(pclk),
      .presetn(presetn),
      .push(push),
      .pop(pop),
      .din(pc_r),
      .dout(stk_top),
      .level(stk_level),
      .full(stk_full),
      .empty(stk_empty)
   );

   // ========================================
   // Command execution.
   always @*
   begin
      acc_nxt = acc_r;
      pc_nxt = pc_r;
      flags_nxt = flags_r;
      push = 1'b0;
      pop = 1'b0;
      if (cmd_wr)
      begin
         pc_nxt = pc_r + 16'h0001;
         case (opc)
            `OPC_ADD_REG_TO_ACC: acc_nxt = acc_r + sel_reg;
            `OPC_ADD_IMM_TO_ACC: acc_nxt = acc_r + imm;
            `OPC_AND_IMM_WITH_ACC: acc_nxt = acc_r & imm;
            `OPC_CALL:
            begin
               if (stk_full)
                  flags_nxt[`FLG_STKERR] = 1'b1;
               else
               begin
                  push = 1'b1;
                  pc_nxt = imm;
               end
            end
            `OPC_RET:
            begin
               if (stk_empty)
                  flags_nxt[`FLG_STKERR] = 1'b1;
               else
               begin
                  pop = 1'b1;
                  pc_nxt = stk_top;
               end
            end
            `OPC_FCLR: flags_nxt[sel[2:0]] = 1'b0;
            `OPC_FSET: flags_nxt[sel[2:0]] = 1'b1;
            `OPC_COMPARE_ACC_REG: flags_nxt = cmp_flags(flags_r, acc_r, sel_reg);
            `OPC_COMPARE_ACC_IMM: flags_nxt = cmp_flags(flags_r, acc_r, imm);
            default: acc_nxt = acc_r;
         endcase
      end
   end

   // ========================================
   // Register read mux.
   always @*
   begin
      rdata_nxt = 32'h00000000;
      rd_err = 1'b0;
      if (greg_hit)
         rdata_nxt = {16'h0000, greg_r[greg_idx]};
      else
      begin
         case (paddr)
            `OFS_CMD: rdata_nxt = 32'h00000000;
            `OFS_ACC: rdata_nxt = {16'h0000, acc_r};
            `OFS_FLAGS: rdata_nxt = {24'h000000, flags_r};
            `OFS_PC: rdata_nxt = {16'h0000, pc_r};
            `OFS_ROLE: rdata_nxt = {29'h00000000, serial_iface_engine_en, role};
            `OFS_PID: rdata_nxt = {30'h00000000, grp1_next_pid};
            `OFS_SP: rdata_nxt = {{(31-STACK_AW){1'b0}}, stk_level};
            default: rd_err = 1'b1;
         endcase
      end
   end

   // ========================================
   // Role and packet identifier for the next cycle.
   always @*
   begin
      role_nxt = role;
      pid_nxt = grp1_next_pid;
      if (cmd_wr)
      begin
         case (opc)
            `OPC_ROLE: role_nxt = sel[1:0];
            `OPC_PID0: pid_nxt = `PID_DATA0;
            `OPC_PID1: pid_nxt = `PID_DATA1;
            `OPC_PID2: pid_nxt = `PID_DATA2;
            `OPC_PFLIP: pid_nxt = pid_flip(grp1_next_pid);
            default: pid_nxt = grp1_next_pid;
         endcase
      end
   end

   // ========================================
   // Bus answer: every access is answered in its first access cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= 1'b0;
         if (rd_setup)
         begin
            prdata <= rdata_nxt;
            pslverr <= rd_err;
         end
         if (wr_setup && !greg_hit && !cmd_hit)
            pslverr <= 1'b1;
      end
   end

   // ========================================
   // General registers, written by software only.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (i = 0; i < NREG; i = i + 1)
            greg_r[i] <= `RST_WORD16;
      end
      else if (wr_done && greg_hit)
         greg_r[greg_idx] <= pwdata[15:0];
   end

   // ========================================
   // Accumulator, program counter and flags.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_r <= `RST_WORD16;
         pc_r <= `RST_WORD16;
         flags_r <= `RST_FLAGS;
      end
      else
      begin
         acc_r <= acc_nxt;
         pc_r <= pc_nxt;
         flags_r <= flags_nxt;
      end
   end

   // ========================================
   // Role outputs and packet identifier.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         role <= `ROLE_DETACHED;
         serial_iface_engine_en <= 1'b0;
         pulldown_dp <= 1'b0;
         pulldown_dm <= 1'b0;
         grp1_next_pid <= `PID_DATA0;
      end
      else
      begin
         role <= role_nxt;
         serial_iface_engine_en <= engine_for(role_nxt);
         pulldown_dp <= pull_dp_for(role_nxt);
         pulldown_dm <= pull_dm_for(role_nxt);
         grp1_next_pid <= pid_nxt;
      end
   end
endmodule // test_script_processor_core

/* File: sim/usb_link_model.sv */
// Far side of the link: a USB party under test with its own line pull-ups.
// Assumes the core's pull-down enables drive the data lines low when set.
`timescale 1ns/1ps
module usb_link_model (
   input wire logic pd_dp,
   input wire logic pd_dm,
   output logic line_dp,
   output logic line_dm
);
   // A line with no pull-down is held high by the far party.
   assign line_dp = !pd_dp;
   assign line_dm = !pd_dm;
endmodule // usb_link_model

/* File: sim/tsp_core_assertions.sv */
// Port checks for the test script processor core.
// Assumes one clock domain, bound to every instance of the core.
`timescale 1ns/1ps
module tsp_core_assertions (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire serial_iface_engine_en,
   input wire pulldown_dp,
   input wire pulldown_dm,
   input wire [1:0] grp1_next_pid,
   input wire [1:0] role
);
   wire wr = psel && penable && pready && pwrite && paddr == 12'h000;
   wire [3:0] op = pwdata[23:20];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========================================
   // Role and packet identifier.
   engine_on_a:
   assert property (serial_iface_engine_en == (role != 2'h0)) else $error("engine enable");
   role_load_a:
   assert property (wr && op == 4'h6 |=> role == $past(pwdata[17:16])) else $error("role load");
   pd_plus_a:
   assert property (pulldown_dp == (role == 2'h1)) else $error("plus pull-down");
   pd_minus_a:
   assert property (pulldown_dm == (role == 2'h1 || role == 2'h3)) else $error("minus pull-down");
   pid_zero_a:
   assert property (wr && op == 4'h9 |=> grp1_next_pid == 2'h0) else $error("pid zero");
   pid_one_a:
   assert property (wr && op == 4'hA |=> grp1_next_pid == 2'h1) else $error("pid one");
   pid_two_a:
   assert property (wr && op == 4'hB |=> grp1_next_pid == 2'h2) else $error("pid two");
   pid_flip_a:
   assert property (wr && op == 4'hC |=> grp1_next_pid == ($past(grp1_next_pid) == 2'h0 ? 2'h1 : 2'h0))
      else $error("pid flip");
endmodule // tsp_core_assertions
bind test_script_processor_core tsp_core_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .serial_iface_engine_en(serial_iface_engine_en),
   .pulldown_dp(pulldown_dp), .pulldown_dm(pulldown_dm), .grp1_next_pid(grp1_next_pid), .role(role));

/* File: sim/test_script_processor_core_tb.sv */
// Self-checking bench: APB master plus a reference model of the core.
// Assumes APB answers within 20 access cycles and the link model beside the core.
`timescale 1ns/1ps
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_script_processor_core_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, eng, pd_dp, pd_dm, l_dp, l_dm;
   wire [1:0] pid, role;
   integer num_errors = 0, checks = 0, seed = 64751, i, r;
   logic [15:0] acc = 16'h0, pc = 16'h0;
   logic [7:0] flg = 8'h00;
   logic [1:0] mpid = 2'h0, mrole = 2'h0;
   logic [15:0] gr [16];
   logic [15:0] stk [$];
   logic [3:0] op, sel;
   always #25 pclk = ~pclk;
   test_script_processor_core i_test_script_processor_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_iface_engine_en(eng), .pulldown_dp(pd_dp), .pulldown_dm(pd_dm),
      .grp1_next_pid(pid), .role(role));
   usb_link_model i_usb_link_model (.pd_dp(pd_dp), .pd_dm(pd_dm), .line_dp(l_dp), .line_dm(l_dm));
   task print_verdict;
   begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         num_errors++;
         print_verdict;
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   end
   endtask
   task cmd(input logic [3:0] o, input logic [3:0] s, input logic [15:0] im);
   begin
      apb(1'b1, 12'h000, {8'h00, o, s, im});
      pc = pc + 16'h1;
      case (o)
         4'h1: acc = acc + gr[s];
         4'h2: acc = acc + im;
         4'h3: acc = acc & im;
         4'h4:
         begin
            if (stk.size() == 8)
               flg[3] = 1'b1;
            else
            begin
               stk.push_back(pc - 16'h1);
               pc = im;
            end
         end
         4'h5: flg[s] = 1'b0;
         4'h6: mrole = s[1:0];
         4'h7: flg[2:0] = {acc > gr[s], acc == gr[s], acc < gr[s]};
         4'h8: flg[2:0] = {acc > im, acc == im, acc < im};
         4'h9: mpid = 2'h0;
         4'hA: mpid = 2'h1;
         4'hB: mpid = 2'h2;
         4'hC: mpid = (mpid == 2'h0) ? 2'h1 : 2'h0;
         4'hD:
         begin
            if (stk.size() == 0)
               flg[3] = 1'b1;
            else
               pc = stk.pop_back();
         end
         4'hE: flg[s] = 1'b1;
         default: ;
      endcase
      apb(1'b0, 12'h004, 32'h0);
      `CK("acc", {16'h0, acc}, rd)
      apb(1'b0, 12'h008, 32'h0);
      `CK("flags", {24'h0, flg}, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CK("pc", {16'h0, pc}, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CK("role reg", {29'h0, mrole != 2'h0, mrole}, rd)
      apb(1'b0, 12'h014, 32'h0);
      `CK("pid reg", {30'h0, mpid}, rd)
      apb(1'b0, 12'h018, 32'h0);
      `CK("level", stk.size(), rd)
      `CK("pid", mpid, pid)
      `CK("role", mrole, role)
      `CK("engine", mrole != 2'h0, eng)
      `CK("lines", {mrole != 2'h1, mrole != 2'h1 && mrole != 2'h3}, {l_dp, l_dm})
   end
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 16; i++)
      begin
         r = $random(seed);
         gr[i] = r[15:0];
         apb(1'b1, 12'(12'h020 + 4 * i), r);
         apb(1'b0, 12'(12'h020 + 4 * i), 32'h0);
         `CK("greg", {16'h0, gr[i]}, rd)
      end
      apb(1'b0, 12'h01C, 32'h0);
      `CK("unmapped", 1'b1, err)
      apb(1'b1, 12'h004, 32'h1234);
      `CK("read-only", 1'b1, err)
      for (i = 0; i < 4; i++)
         cmd(4'h6, i[3:0], 16'h0);
      cmd(4'h2, 4'h0, 16'hFFFF);
      cmd(4'h2, 4'h0, 16'h0002);
      cmd(4'h8, 4'h0, 16'h0001);
      cmd(4'hB, 4'h0, 16'h0);
      cmd(4'hC, 4'h0, 16'h0);
      for (i = 0; i < 200; i++)
      begin
         r = $random(seed);
         op = r[23:20];
         sel = r[19:16];
         if (op == 4'h5 || op == 4'hE)
            sel[3:2] = 2'b00;
         if (op == 4'hF)
            op = 4'h0;
         cmd(op, sel, r[15:0]);
      end
      print_verdict;
   end
endmodule // test_script_processor_core_tb
